// ===== dv/bfc_flash_model.sv
// Behavioural model of the banked flash as seen at its pins.
`timescale 1ns/1ns
`default_nettype none
module bfc_flash_model
  import bfc_pkg::*;
(
  input wire logic [21:0] addr,
  input wire logic [15:0] wdata,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic reset_n,
  input wire logic protect_n,
  input wire logic accel,
  output logic [15:0] rdata,
  output logic readyBusy_n
);
  logic [15:0] mem [int];
  logic [15:0] pend = 16'h0;
  logic [15:0] last = 16'h0;
  logic bypass = 1'b0;
  logic busy = 1'b0;
  logic tog = 1'b0;
  int step = 0;
  int pAddr = 0;
  initial readyBusy_n = 1'b1;
  // Eight small sectors of 4 Kw sit at the bottom, 32 Kw sectors above them.
  function automatic int sec(int a);
    return (a < 32'h8000) ? a >> 12 : (a >> 15) + 8;
  endfunction
  function automatic logic [15:0] peek(int a);
    return mem.exists(a) ? mem[a] : 16'hffff;
  endfunction
  // Embedded program: timed busy, then commit unless the sector is guarded.
  task automatic run();
    busy = 1'b1;
    readyBusy_n = 1'b0;
    #(accel ? 40 : 120);
    if (busy && !(!protect_n && pAddr < 32'h2000)) mem[pAddr] = peek(pAddr) & pend;
    busy = 1'b0;
    readyBusy_n = 1'b1;
  endtask
  // Each write cycle is latched at the closing edge of the write pulse.
  always @(posedge we_n) begin
    if (!ce_n && reset_n && !busy) begin
      // The data cycle goes first, so any program word is taken as data.
      if (step == 3) begin
        pend = wdata;
        pAddr = int'(addr);
        step = 0;
        fork
          run();
        join_none
      end else if (step == 8) begin
        // Erase is immediate here; cells outside the target keep their data.
        pAddr = int'(addr);
        foreach (mem[k]) begin
          if (wdata == CMD_CHIP_ERASE || sec(k) == sec(pAddr)) mem[k] = 16'hffff;
        end
        step = 0;
      end else if (wdata == CMD_RESET) step = 0;
      else if (step == 0 && bypass && wdata == CMD_PROGRAM) step = 3;
      else if (step == 0 && bypass && wdata == CMD_BYPASS_EXIT1) step = 5;
      else if (step == 5) begin
        bypass = 1'b0;
        step = 0;
      end else if (step == 0 && wdata == UNLOCK_DATA1 && addr[11:0] == UNLOCK_ADDR1[11:0]) step = 1;
      else if (step == 1 && wdata == UNLOCK_DATA2 && addr[11:0] == UNLOCK_ADDR2[11:0]) step = 2;
      else if (step == 2 && wdata == CMD_PROGRAM) step = 3;
      else if (step == 2 && wdata == CMD_ERASE_SETUP) step = 6;
      else if (step == 6 && wdata == UNLOCK_DATA1) step = 7;
      else if (step == 7 && wdata == UNLOCK_DATA2) step = 8;
      else if (step == 2 && wdata == CMD_BYPASS_ENTER) begin
        bypass = 1'b1;
        step = 0;
      end else step = 0;
    end
  end
  // Hardware reset drops any sequence and abandons the embedded cycle.
  always @(negedge reset_n) begin
    step = 0;
    bypass = 1'b0;
    busy = 1'b0;
    readyBusy_n = 1'b1;
  end
  always @(negedge oe_n) if (busy) tog = ~tog;
  always @(posedge oe_n) last = rdata;
  // A released bus shows the inverse of the last word, never a stale copy.
  always @* begin
    if (!oe_n && !ce_n) rdata = busy ? {8'h00, ~pend[7], tog, 6'h00} : peek(int'(addr));
    else rdata = ~last;
  end
endmodule
`default_nettype wire

// ===== dv/bfc_flash_monitor.sv
// Checker of the pin and register relations of the flash controller.
`timescale 1ns/1ns
`default_nettype none
module bfc_flash_monitor
  import bfc_pkg::*;
#(
  parameter int ADDR_W = 22,
  parameter int DATA_W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [31:0] regRdata,
  input wire logic [ADDR_W-1:0] flashAddr,
  input wire logic [DATA_W-1:0] word_data_lines_out,
  input wire logic word_data_lines_oe,
  input wire logic chipEnable_n,
  input wire logic writeEnable_n,
  input wire logic outputEnable_n,
  input wire logic hwReset_n,
  input wire logic protect_accel_pin,
  input wire logic program_accel_in
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // -------------------------------------------------------------
  // Bus cycle shape on the flash pins.
  // -------------------------------------------------------------
  a_rdata_idle: assert property (!$past(regRead) |-> regRdata == 32'h0)
    else $error("read data not zero outside a read answer");
  a_we_oe_apart: assert property (!(!writeEnable_n && !outputEnable_n))
    else $error("write and read enables low together");
  a_drive_write: assert property (!writeEnable_n |-> word_data_lines_oe)
    else $error("write pulse without driven data");
  a_read_undriven: assert property (!outputEnable_n |-> !word_data_lines_oe)
    else $error("data lines driven during a read");
  a_pulse_width: assert property ($fell(writeEnable_n) |-> !writeEnable_n [*8])
    else $error("write pulse too short");
  a_cmd_stable: assert property (!writeEnable_n && !$past(writeEnable_n) |->
    $stable(flashAddr) && $stable(word_data_lines_out))
    else $error("address or data moved inside a write pulse");
  // The static control pins may only move in the cycle after a register write.
  a_pins_hold: assert property (!$past(regWrite) |->
    $stable(program_accel_in) && $stable(protect_accel_pin))
    else $error("control pins moved without a register write");
  a_select_active: assert property (!writeEnable_n || !outputEnable_n |-> !chipEnable_n)
    else $error("bus cycle without chip select");
  a_hwrst_hold: assert property ($fell(hwReset_n) |-> !hwReset_n [*8])
    else $error("hardware reset pulse too short");
  // A write refused while busy leaves the pin alone, hence the stable escape.
  a_accel_follow: assert property ($past(regWrite && regAddr == REG_CTRL) |->
    program_accel_in == $past(regWdata[CTRL_ACCEL_BIT]) || $stable(program_accel_in))
    else $error("acceleration pin does not follow control word");
  a_wp_follow: assert property ($past(regWrite && regAddr == REG_CTRL) |->
    protect_accel_pin == !$past(regWdata[CTRL_WPROT_BIT]) || $stable(protect_accel_pin))
    else $error("protect pin does not follow control word");
  c_write_pulse: cover property ($fell(writeEnable_n));
  c_read_pulse: cover property ($fell(outputEnable_n));
  c_hw_reset: cover property ($fell(hwReset_n));
endmodule
bind bfc_flash_host bfc_flash_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) bfc_flash_monitor_i (
  .clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
  .regRead(regRead), .regRdata(regRdata), .flashAddr(flashAddr),
  .word_data_lines_out(word_data_lines_out), .word_data_lines_oe(word_data_lines_oe),
  .chipEnable_n(chipEnable_n), .writeEnable_n(writeEnable_n),
  .outputEnable_n(outputEnable_n), .hwReset_n(hwReset_n),
  .protect_accel_pin(protect_accel_pin), .program_accel_in(program_accel_in));
`default_nettype wire

// ===== dv/tb.sv
// Self-checking bench of the flash controller against a flash model.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import bfc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [3:0] fl = 4'h0;
  logic [31:0] regWdata = 32'h0;
  logic [31:0] regRdata;
  logic [31:0] rv;
  logic [21:0] flashAddr;
  logic [15:0] lineOut, lineIn, devOut, d;
  logic lineOe, ce_n, we_n, oe_n, hw_n, prot_n, accel, rdy_n;
  int error_cnt = 0;
  int checks_done = 0;
  int seed = 95254;
  int cyc = 0;
  int a, i;
  logic [15:0] refMem [int];
  always #2 clk = ~clk;
  assign lineIn = lineOe ? lineOut : devOut;
  bfc_flash_host #(.POLL_LIMIT(50)) bfc_flash_host_i (.clk(clk), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .flashAddr(flashAddr), .word_data_lines_in(lineIn), .word_data_lines_out(lineOut),
    .word_data_lines_oe(lineOe), .chipEnable_n(ce_n), .writeEnable_n(we_n),
    .outputEnable_n(oe_n), .hwReset_n(hw_n), .protect_accel_pin(prot_n),
    .program_accel_in(accel), .ready_busy_n_out(rdy_n));
  bfc_flash_model bfc_flash_model_i (.addr(flashAddr), .wdata(lineOut), .ce_n(ce_n), .we_n(we_n),
    .oe_n(oe_n), .reset_n(hw_n), .protect_n(prot_n), .accel(accel), .rdata(devOut),
    .readyBusy_n(rdy_n));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // The timeout covers every scenario with a wide margin.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // -------------------------------------------------------------
  // Register port cycles; every drive lands on a rising edge.
  // -------------------------------------------------------------
  // An idle edge after each strobe keeps two calls from driving one signal at once.
  task automatic wr(logic [3:0] ad, logic [31:0] dt);
    regAddr <= ad;
    regWdata <= dt;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    @(posedge clk);
  endtask
  // The answer stands in the cycle after the strobe and is taken at its closing edge.
  task automatic rd(logic [3:0] ad, output logic [31:0] dt);
    regAddr <= ad;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(posedge clk);
    dt = regRdata;
  endtask
  task automatic start(logic [3:0] code, int ad, logic [15:0] dt);
    wr(REG_ADDR, ad);
    wr(REG_WDATA, {16'h0, dt});
    wr(REG_CTRL, {23'h0, fl, 1'b1, code});
  endtask
  task automatic wt(logic fail);
    for (int n = 0; n < 3000; n++) begin
      rd(REG_STAT, rv);
      if (rv[STAT_DONE_BIT] === 1'b1) break;
    end
    chk(rv[2:1], {fail, 1'b1});
  endtask
  // Expected word after a program, from the guarded range and AND-only cells.
  task automatic pg(int ad, logic [15:0] dt);
    logic [15:0] old, fin;
    old = refMem.exists(ad) ? refMem[ad] : 16'hffff;
    fin = (fl[1] && ad < 32'h2000) ? old : old & dt;
    refMem[ad] = fin;
    start(OP_PROGRAM, ad, dt);
    wt(fin[7] != dt[7]);
  endtask
  task automatic rdw(int ad);
    start(OP_READ, ad, 16'h0);
    wt(1'b0);
    rd(REG_RDATA, rv);
    chk(rv[15:0], refMem.exists(ad) ? refMem[ad] : 16'hffff);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(REG_STAT, rv);
    chk(rv[5:0], 32'h08);
    rd(4'hf, rv);
    chk(rv, 32'h0);
    $display("test reset values done");
    for (i = 0; i < 4; i++) begin
      a = 32'h2000 + ($random(seed) & 32'hfff8);
      d = 16'($random(seed));
      pg(a, d);
      rdw(a);
      rdw(a + 5);
    end
    $display("test program and page read done");
    start(OP_BYPASS_ENTER, 0, 16'h0);
    wt(1'b0);
    rd(REG_STAT, rv);
    chk(rv[STAT_BYPASS_BIT], 1'b1);
    for (i = 0; i < 3; i++) pg(32'h3000 + i, 16'($random(seed)) & 16'hff7f);
    start(OP_BYPASS_EXIT, 0, 16'h0);
    wt(1'b0);
    for (i = 0; i < 3; i++) rdw(32'h3000 + i);
    $display("test bypass done");
    fl = 4'h1;
    pg(32'h4100, 16'h1234);
    chk(accel, 1'b1);
    fl = 4'h2;
    pg(32'h0100, 16'h0000);
    chk(prot_n, 1'b0);
    rdw(32'h0100);
    fl = 4'h0;
    pg(32'h0100, 16'h5a00);
    rdw(32'h0100);
    $display("test protect and accel done");
    start(OP_BYPASS_ENTER, 0, 16'h0);
    wt(1'b0);
    wr(REG_CTRL, 32'h100);
    repeat (RESET_CYC + 20) @(posedge clk);
    rd(REG_STAT, rv);
    chk(rv[STAT_BYPASS_BIT], 1'b0);
    pg(32'h5000, 16'h00ff);
    rdw(32'h5000);
    $display("test hardware reset done");
    pg(32'h8003, 16'h1234);
    start(OP_SECTOR_ERASE, 32'h8000, 16'h0);
    wt(1'b0);
    foreach (refMem[k]) if (k >= 32'h8000 && k < 32'h10000) refMem[k] = 16'hffff;
    rdw(32'h8003);
    rdw(32'h5000);
    start(OP_SUSPEND, 0, 16'h0);
    wt(1'b0);
    rd(REG_STAT, rv);
    chk(rv[STAT_SUSP_BIT], 1'b1);
    start(OP_RESUME, 0, 16'h0);
    wt(1'b0);
    rd(REG_STAT, rv);
    chk(rv[STAT_SUSP_BIT], 1'b0);
    for (i = 8; i < 12; i++) begin
      start(4'(i), 0, 16'h0);
      wt(1'b0);
    end
    start(OP_CHIP_ERASE, 0, 16'h0);
    wt(1'b0);
    foreach (refMem[k]) refMem[k] = 16'hffff;
    rdw(32'h5000);
    $display("test erase suspend and modes done");
    start(OP_PROGRAM, 32'h6000, 16'h0f0f);
    wr(REG_ADDR, 32'h6001);
    refMem[32'h6000] = 16'h0f0f;
    wt(1'b0);
    rdw(32'h6000);
    fl = 4'h4;
    rdw(32'h6000);
    repeat (3) @(posedge clk);
    chk(ce_n, 1'b1);
    $display("test busy refusal and standby done");
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ===== rtl/bfc_flash_host.sv
// Host-side controller that drives a banked NOR flash through its pins.
// What this block does
// - Bypass mode programs with two write cycles.
// - Commands are ordinary bus write cycles.
// - Poll bit 7 inverted, bit 6 toggles.
// - Secured sector read during suspend needs entry/exit.
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module bfc_flash_host
  import bfc_pkg::*;
#(
  parameter int ADDR_W = 22,
  parameter int DATA_W = 16,
  parameter int POLL_LIMIT = 65535
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  output logic [ADDR_W-1:0] flashAddr,
  input wire logic [DATA_W-1:0] word_data_lines_in,
  output logic [DATA_W-1:0] word_data_lines_out,
  output logic word_data_lines_oe,
  output logic chipEnable_n,
  output logic writeEnable_n,
  output logic outputEnable_n,
  output logic hwReset_n,
  output logic protect_accel_pin,
  output logic program_accel_in,
  input wire logic ready_busy_n_out
);
  // ---------------------------------------------------------------
  // State.
  // ---------------------------------------------------------------
  bfc_state_t state_r, state_nxt;
  logic [8:0] ctrl_r, ctrl_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt, fAddr_r, fAddr_nxt;
  logic [DATA_W-1:0] wdata_r, wdata_nxt, fData_r, fData_nxt, rdata_r, rdata_nxt;
  logic [DATA_W-1:0] lastPoll_r, lastPoll_nxt;
  logic [2:0] step_r, step_nxt, nSteps_r, nSteps_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [16:0] polls_r, polls_nxt;
  logic busy_r, busy_nxt, done_r, done_nxt, fail_r, fail_nxt;
  logic bypass_r, bypass_nxt, susp_r, susp_nxt, pollOp_r, pollOp_nxt;
  logic pageOk_r, pageOk_nxt, oe_r, oe_nxt, we_r, we_nxt, ce_r, ce_nxt, rstn_r, rstn_nxt;
  logic [ADDR_W-4:0] page_r, page_nxt;
  logic [31:0] rd_r, rd_nxt;
  // Command sequence table: one address/data pair per bus write step.
  logic [ADDR_W-1:0] seqA;
  logic [DATA_W-1:0] seqD;
  logic [2:0] seqLen;
  logic seqPoll;
  bfc_op_t op;
  assign op = bfc_op_t'(ctrl_r[CTRL_OP_LSB +: 4]);
  // Builds each write cycle of the chosen command; bypass shortens program.
  always_comb begin
    // Command addresses are 16 bits wide and are zero-extended onto the flash address.
    seqA = ADDR_W'(UNLOCK_ADDR1);
    seqD = UNLOCK_DATA1;
    seqLen = 3'd4;
    seqPoll = 1'b0;
    unique case (op)
      OP_PROGRAM: begin
        seqPoll = 1'b1;
        if (bypass_r) begin
          seqLen = 3'd2;
          seqA = (step_r == 3'd0) ? addr_r : addr_r;
          seqD = (step_r == 3'd0) ? CMD_PROGRAM : wdata_r;
        end else begin
          seqA = (step_r == 3'd1) ? ADDR_W'(UNLOCK_ADDR2) :
                 (step_r == 3'd3) ? addr_r : ADDR_W'(UNLOCK_ADDR1);
          seqD = (step_r == 3'd0) ? UNLOCK_DATA1 : (step_r == 3'd1) ? UNLOCK_DATA2 :
                 (step_r == 3'd2) ? CMD_PROGRAM : wdata_r;
        end
      end
      OP_SECTOR_ERASE, OP_CHIP_ERASE: begin
        seqLen = 3'd6;
        seqPoll = 1'b1;
        seqA = (step_r == 3'd1 || step_r == 3'd4) ? ADDR_W'(UNLOCK_ADDR2) :
               (step_r == 3'd5 && op == OP_SECTOR_ERASE) ? addr_r :
               ADDR_W'(UNLOCK_ADDR1);
        seqD = (step_r == 3'd0 || step_r == 3'd3) ? UNLOCK_DATA1 :
               (step_r == 3'd1 || step_r == 3'd4) ? UNLOCK_DATA2 :
               (step_r == 3'd2) ? CMD_ERASE_SETUP :
               (op == OP_SECTOR_ERASE) ? CMD_SECTOR_ERASE : CMD_CHIP_ERASE;
      end
      OP_BYPASS_ENTER, OP_SECURE_ENTER, OP_SECURE_EXIT: begin
        seqLen = (op == OP_SECURE_EXIT) ? 3'd4 : 3'd3;
        seqA = (step_r == 3'd1) ? ADDR_W'(UNLOCK_ADDR2) : ADDR_W'(UNLOCK_ADDR1);
        seqD = (step_r == 3'd0) ? UNLOCK_DATA1 : (step_r == 3'd1) ? UNLOCK_DATA2 :
               (step_r == 3'd3) ? CMD_BYPASS_EXIT2 :
               (op == OP_BYPASS_ENTER) ? CMD_BYPASS_ENTER :
               (op == OP_SECURE_ENTER) ? CMD_SECURE_ENTER : CMD_SECURE_EXIT;
      end
      OP_BYPASS_EXIT: begin
        seqLen = 3'd2;
        seqA = addr_r;
        seqD = (step_r == 3'd0) ? CMD_BYPASS_EXIT1 : CMD_BYPASS_EXIT2;
      end
      OP_SUSPEND, OP_RESUME, OP_QUERY, OP_RESET_CMD: begin
        seqLen = 3'd1;
        seqA = (op == OP_QUERY) ? ADDR_W'(QUERY_ADDR) : addr_r;
        seqD = (op == OP_SUSPEND) ? CMD_SUSPEND : (op == OP_RESUME) ? CMD_RESUME :
               (op == OP_QUERY) ? CMD_QUERY : CMD_RESET;
        seqPoll = (op == OP_RESUME);
      end
      default: begin
        seqLen = 3'd0;
      end
    endcase
  end
  // ---------------------------------------------------------------
  // Main sequencer: register writes start work, the pins follow it.
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    ctrl_nxt = ctrl_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    fAddr_nxt = fAddr_r;
    fData_nxt = fData_r;
    rdata_nxt = rdata_r;
    lastPoll_nxt = lastPoll_r;
    step_nxt = step_r;
    nSteps_nxt = nSteps_r;
    cnt_nxt = cnt_r;
    polls_nxt = polls_r;
    busy_nxt = busy_r;
    done_nxt = done_r;
    fail_nxt = fail_r;
    bypass_nxt = bypass_r;
    susp_nxt = susp_r;
    pollOp_nxt = pollOp_r;
    pageOk_nxt = pageOk_r;
    page_nxt = page_r;
    oe_nxt = 1'b0;
    we_nxt = 1'b0;
    ce_nxt = 1'b0;
    rstn_nxt = 1'b1;
    // Status reads: a read clears the sticky done and fail flags,
    // but a completion in the same cycle wins below.
    rd_nxt = 32'h0;
    if (regRead) begin
      unique case (regAddr)
        REG_CTRL: rd_nxt = {23'h0, ctrl_r};
        REG_ADDR: rd_nxt = {{(32-ADDR_W){1'b0}}, addr_r};
        REG_WDATA: rd_nxt = {16'h0, wdata_r};
        REG_STAT: begin
          rd_nxt = {26'h0, susp_r, bypass_r, ready_busy_n_out, fail_r, done_r, busy_r};
          done_nxt = 1'b0;
          fail_nxt = 1'b0;
        end
        REG_RDATA: rd_nxt = {16'h0, rdata_r};
        default: rd_nxt = 32'h0;
      endcase
    end
    // A latched start or reset counts as busy, so no write can alter a command in flight.
    if (regWrite && !busy_r && !ctrl_r[CTRL_GO_BIT] && !ctrl_r[CTRL_RESET_BIT]) begin
      unique case (regAddr)
        REG_CTRL: ctrl_nxt = regWdata[8:0];
        REG_ADDR: addr_nxt = regWdata[ADDR_W-1:0];
        REG_WDATA: wdata_nxt = regWdata[DATA_W-1:0];
        default: ;
      endcase
    end
    unique case (state_r)
      ST_IDLE: begin
        ce_nxt = ctrl_r[CTRL_STANDBY_BIT];
        if (ctrl_r[CTRL_RESET_BIT]) begin
          ctrl_nxt[CTRL_RESET_BIT] = 1'b0;
          cnt_nxt = 8'(RESET_CYC);
          busy_nxt = 1'b1;
          state_nxt = ST_HWRST;
        end else if (ctrl_r[CTRL_GO_BIT]) begin
          ctrl_nxt[CTRL_GO_BIT] = 1'b0;
          busy_nxt = 1'b1;
          step_nxt = 3'd0;
          if (op == OP_READ) begin
            // Same 8-word page as last read takes the short access.
            cnt_nxt = (pageOk_r && page_r == addr_r[ADDR_W-1:3]) ?
                      8'(PAGE_CYC) : 8'(READ_CYC);
            page_nxt = addr_r[ADDR_W-1:3];
            pageOk_nxt = 1'b1;
            state_nxt = ST_READ;
          end else begin
            nSteps_nxt = seqLen;
            pollOp_nxt = seqPoll;
            pageOk_nxt = 1'b0;
            cnt_nxt = 8'(WRITE_CYC);
            state_nxt = ST_WRITE;
          end
        end
      end
      ST_WRITE: begin
        fAddr_nxt = seqA;
        fData_nxt = seqD;
        we_nxt = 1'b1;
        oe_nxt = 1'b0;
        cnt_nxt = cnt_r - 8'd1;
        if (cnt_r == 8'd1) begin
          cnt_nxt = 8'(WRITE_CYC);
          state_nxt = ST_GAP;
        end
      end
      ST_GAP: begin
        cnt_nxt = cnt_r - 8'd1;
        if (cnt_r == 8'd1) begin
          cnt_nxt = 8'(WRITE_CYC);
          if (step_r + 3'd1 < nSteps_r) begin
            step_nxt = step_r + 3'd1;
            state_nxt = ST_WRITE;
          end else if (pollOp_r) begin
            polls_nxt = 17'd0;
            fAddr_nxt = addr_r;
            cnt_nxt = 8'(READ_CYC);
            state_nxt = ST_POLL;
          end else begin
            if (op == OP_BYPASS_ENTER) bypass_nxt = 1'b1;
            if (op == OP_BYPASS_EXIT || op == OP_RESET_CMD) bypass_nxt = 1'b0;
            if (op == OP_SUSPEND) susp_nxt = 1'b1;
            busy_nxt = 1'b0;
            done_nxt = 1'b1;
            state_nxt = ST_IDLE;
          end
        end
      end
      ST_READ: begin
        fAddr_nxt = addr_r;
        oe_nxt = 1'b1;
        cnt_nxt = cnt_r - 8'd1;
        if (cnt_r == 8'd1) begin
          rdata_nxt = word_data_lines_in;
          busy_nxt = 1'b0;
          done_nxt = 1'b1;
          state_nxt = ST_IDLE;
        end
      end
      ST_POLL: begin
        // Two reads in a row that agree mean the toggle bit has stopped.
        oe_nxt = (cnt_r != 8'd1);
        cnt_nxt = cnt_r - 8'd1;
        if (cnt_r == 8'd1) begin
          lastPoll_nxt = word_data_lines_in;
          polls_nxt = polls_r + 17'd1;
          cnt_nxt = 8'(READ_CYC);
          if (polls_r != 17'd0 && word_data_lines_in[6] == lastPoll_r[6]) begin
            // A protected target ends with wrong data; flag it.
            fail_nxt = (op == OP_PROGRAM) && (word_data_lines_in[7] != wdata_r[7]);
            rdata_nxt = word_data_lines_in;
            if (op == OP_RESUME) susp_nxt = 1'b0;
            busy_nxt = 1'b0;
            done_nxt = 1'b1;
            state_nxt = ST_IDLE;
          end else if (polls_r == 17'(POLL_LIMIT)) begin
            fail_nxt = 1'b1;
            busy_nxt = 1'b0;
            done_nxt = 1'b1;
            state_nxt = ST_IDLE;
          end
        end
      end
      ST_HWRST: begin
        rstn_nxt = 1'b0;
        cnt_nxt = cnt_r - 8'd1;
        if (cnt_r == 8'd1) begin
          bypass_nxt = 1'b0;
          susp_nxt = 1'b0;
          pageOk_nxt = 1'b0;
          busy_nxt = 1'b0;
          done_nxt = 1'b1;
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end
  // Registers only.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      ctrl_r <= 9'h000;
      addr_r <= '0;
      wdata_r <= '0;
      fAddr_r <= '0;
      fData_r <= '0;
      rdata_r <= '0;
      lastPoll_r <= '0;
      step_r <= 3'h0;
      nSteps_r <= 3'h0;
      cnt_r <= 8'h00;
      polls_r <= 17'h00000;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      fail_r <= 1'b0;
      bypass_r <= 1'b0;
      susp_r <= 1'b0;
      pollOp_r <= 1'b0;
      pageOk_r <= 1'b0;
      page_r <= '0;
      oe_r <= 1'b0;
      we_r <= 1'b0;
      ce_r <= 1'b0;
      rstn_r <= 1'b0;
      rd_r <= 32'h0;
    end else begin
      state_r <= state_nxt;
      ctrl_r <= ctrl_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      fAddr_r <= fAddr_nxt;
      fData_r <= fData_nxt;
      rdata_r <= rdata_nxt;
      lastPoll_r <= lastPoll_nxt;
      step_r <= step_nxt;
      nSteps_r <= nSteps_nxt;
      cnt_r <= cnt_nxt;
      polls_r <= polls_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      fail_r <= fail_nxt;
      bypass_r <= bypass_nxt;
      susp_r <= susp_nxt;
      pollOp_r <= pollOp_nxt;
      pageOk_r <= pageOk_nxt;
      page_r <= page_nxt;
      oe_r <= oe_nxt;
      we_r <= we_nxt;
      ce_r <= ce_nxt;
      rstn_r <= rstn_nxt;
      rd_r <= rd_nxt;
    end
  end
  // ---------------------------------------------------------------
  // Pins from flip-flops; chip enable is also gated with the idle state.
  // ---------------------------------------------------------------
  assign regRdata = rd_r;
  assign flashAddr = fAddr_r;
  assign word_data_lines_out = fData_r;
  assign word_data_lines_oe = we_r;
  assign writeEnable_n = ~we_r;
  assign outputEnable_n = ~oe_r;
  // Chip stays deselected (standby) only when idle and standby is asked.
  assign chipEnable_n = ce_r && (state_r == ST_IDLE);
  assign hwReset_n = rstn_r;
  assign protect_accel_pin = ~ctrl_r[CTRL_WPROT_BIT];
  assign program_accel_in = ctrl_r[CTRL_ACCEL_BIT];
endmodule
`default_nettype wire

// ===== rtl/bfc_pkg.sv
// Package of constants and types for the banked flash command controller.
package bfc_pkg;
  // ---------------------------------------------------------------
  // Host register map of the controller.
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_WDATA = 4'h2;
  localparam logic [3:0] REG_STAT = 4'h3;
  localparam logic [3:0] REG_RDATA = 4'h4;
  // Control word fields (opcode in the low nibble, flags above).
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_GO_BIT = 4;
  localparam int CTRL_ACCEL_BIT = 5;
  localparam int CTRL_WPROT_BIT = 6;
  localparam int CTRL_STANDBY_BIT = 7;
  localparam int CTRL_RESET_BIT = 8;
  // Status word fields.
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_FAIL_BIT = 2;
  localparam int STAT_RDY_BIT = 3;
  localparam int STAT_BYPASS_BIT = 4;
  localparam int STAT_SUSP_BIT = 5;
  // ---------------------------------------------------------------
  // Command cycle codes written on the word data lines.
  // ---------------------------------------------------------------
  localparam logic [15:0] UNLOCK_ADDR1 = 16'h0555;
  localparam logic [15:0] UNLOCK_ADDR2 = 16'h02aa;
  localparam logic [15:0] UNLOCK_DATA1 = 16'h00aa;
  localparam logic [15:0] UNLOCK_DATA2 = 16'h0055;
  localparam logic [15:0] CMD_PROGRAM = 16'h00a0;
  localparam logic [15:0] CMD_ERASE_SETUP = 16'h0080;
  localparam logic [15:0] CMD_SECTOR_ERASE = 16'h0030;
  localparam logic [15:0] CMD_CHIP_ERASE = 16'h0010;
  localparam logic [15:0] CMD_BYPASS_ENTER = 16'h0020;
  localparam logic [15:0] CMD_BYPASS_EXIT1 = 16'h0090;
  localparam logic [15:0] CMD_BYPASS_EXIT2 = 16'h0000;
  localparam logic [15:0] CMD_SUSPEND = 16'h00b0;
  localparam logic [15:0] CMD_RESUME = 16'h0030;
  localparam logic [15:0] CMD_RESET = 16'h00f0;
  localparam logic [15:0] CMD_SECURE_ENTER = 16'h0088;
  localparam logic [15:0] CMD_SECURE_EXIT = 16'h0090;
  localparam logic [15:0] CMD_QUERY = 16'h0098;
  localparam logic [15:0] QUERY_ADDR = 16'h0055;
  // ---------------------------------------------------------------
  // Timing at 250 MHz.
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int T_WRITE_NS = 40;
  localparam int T_READ_NS = 70;
  localparam int T_PAGE_NS = 25;
  localparam int T_RESET_NS = 500;
  localparam int WRITE_CYC = (T_WRITE_NS * CLK_MHZ + 999) / 1000;
  localparam int READ_CYC = (T_READ_NS * CLK_MHZ + 999) / 1000;
  localparam int PAGE_CYC = (T_PAGE_NS * CLK_MHZ + 999) / 1000;
  localparam int RESET_CYC = (T_RESET_NS * CLK_MHZ + 999) / 1000;
  localparam int PAGE_WORDS = 8;
  // Host operation codes.
  typedef enum logic [3:0] {
    OP_READ = 4'h0,
    OP_PROGRAM = 4'h1,
    OP_SECTOR_ERASE = 4'h2,
    OP_CHIP_ERASE = 4'h3,
    OP_BYPASS_ENTER = 4'h4,
    OP_BYPASS_EXIT = 4'h5,
    OP_SUSPEND = 4'h6,
    OP_RESUME = 4'h7,
    OP_SECURE_ENTER = 4'h8,
    OP_SECURE_EXIT = 4'h9,
    OP_QUERY = 4'ha,
    OP_RESET_CMD = 4'hb
  } bfc_op_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WRITE = 3'b001,
    ST_GAP = 3'b010,
    ST_READ = 3'b011,
    ST_POLL = 3'b100,
    ST_HWRST = 3'b101
  } bfc_state_t;
endpackage
